// [hw/bst_cfg.svh]
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
`define BST_IR_W        4
`define BST_IR_CAPTURE  4'h1
`define BST_IR_RESET    4'hf
`define BST_OP_EXTEST   4'h0
`define BST_OP_SAMPLE   4'h1
`define BST_OP_IDCODE   4'h2
`define BST_OP_HIZ      4'h3
`define BST_OP_BYPASS   4'hf
`define BST_ID_W        32
`define BST_ID_LSB      1'h1
`define BST_BSR_W       8
`define BST_TMS_RESET_N 5
`endif

// [hw/bst_pkg.sv]
package bst_pkg;
	typedef enum logic [15:0] {
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SEL_DR  = 16'h0004,
		ST_CAP_DR  = 16'h0008,
		ST_SH_DR   = 16'h0010,
		ST_EX1_DR  = 16'h0020,
		ST_PAU_DR  = 16'h0040,
		ST_EX2_DR  = 16'h0080,
		ST_UPD_DR  = 16'h0100,
		ST_SEL_IR  = 16'h0200,
		ST_CAP_IR  = 16'h0400,
		ST_SH_IR   = 16'h0800,
		ST_EX1_IR  = 16'h1000,
		ST_PAU_IR  = 16'h2000,
		ST_EX2_IR  = 16'h4000,
		ST_UPD_IR  = 16'h8000
	} bst_state_t;
	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h1,
		SEL_BSR    = 3'h2,
		SEL_ID     = 3'h4
	} bst_sel_t;
endpackage

// [hw/bst_tap.sv]
`timescale 1ns/100ps
`include "bst_cfg.svh"
// Overview of operation
// - five tms-high edges force reset state
// - test port overrides fifo pin operation
// - transitions on rising edge, tms chooses
// - capture-dr loads pins or core values
// - shift lsb first, tdo on falling
// - update-dr moves shift into output latches
// - exit with tms high goes update
// - pause-dr holds all selected registers
// - ir states mirror dr states
// - ir shifts, new code at update-ir
// - four-bit ir, lsb nearest tdo
// - data registers parallel, instruction selects
// - bypass single stage, captures zero
// - bypass leaves device operation untouched
// - boundary cells load and read pins
// - decode extest sample idcode hiz bypass
// - read-only 32-bit id register shifts out
module bst_tap
	import bst_pkg::*;
#(
	parameter logic [3:0]  ID_VERSION = 4'h0,   // arbitrary value
	parameter logic [15:0] ID_PART    = 16'h0000, // arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h000  // arbitrary value
)
(
	// system
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	// test port pins
	input  wire logic                   test_port_clock,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	input  wire logic                   trst_n,
	output logic                        tdo,
	output logic                        tdo_oe,
	// core side
	input  wire logic [`BST_BSR_W-1:0]  pin_in,
	input  wire logic [`BST_BSR_W-1:0]  core_out,
	output logic [`BST_BSR_W-1:0]       pin_out,
	output logic                        test_override,
	output logic                        outputs_hiz,
	output logic                        tap_in_reset
);
	logic [2:0]              tck_s_r;
	logic [1:0]              tms_s_r;
	logic [1:0]              tdi_s_r;
	logic [1:0]              trst_s_r;
	logic                    rise;
	logic                    fall;
	logic                    trst_sync_n;
	bst_state_t              st_r;
	bst_state_t              st_nxt;
	logic [`BST_IR_W-1:0]    ir_sh_r;
	logic [`BST_IR_W-1:0]    ir_r;
	logic                    byp_r;
	logic [`BST_BSR_W-1:0]   bsr_sh_r;
	logic [`BST_BSR_W-1:0]   bsr_upd_r;
	logic [`BST_ID_W-1:0]    id_sh_r;
	bst_sel_t                sel;
	logic                    sout;
	logic                    tms_v;
	logic                    tdi_v;
	logic [2:0]              hi_run_r;

	// pins pass two flops before use
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tck_s_r  <= 3'h0;
			tms_s_r  <= 2'h3;
			tdi_s_r  <= 2'h0;
			trst_s_r <= 2'h0;
		end
		else if (clk_en)
		begin
			tck_s_r  <= {tck_s_r[1:0], test_port_clock};
			tms_s_r  <= {tms_s_r[0], tms};
			tdi_s_r  <= {tdi_s_r[0], tdi};
			trst_s_r <= {trst_s_r[0], trst_n};
		end
	end

	assign tms_v       = tms_s_r[1];
	assign tdi_v       = tdi_s_r[1];
	assign trst_sync_n = trst_s_r[1];
	assign rise        = clk_en && tck_s_r[1] && !tck_s_r[2];
	assign fall        = clk_en && !tck_s_r[1] && tck_s_r[2];

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_RESET:  st_nxt = tms_v ? ST_RESET  : ST_IDLE;
			ST_IDLE:   st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: st_nxt = tms_v ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_nxt = tms_v ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: st_nxt = tms_v ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: st_nxt = tms_v ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: st_nxt = tms_v ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_nxt = tms_v ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: st_nxt = tms_v ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: st_nxt = tms_v ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
			default:   st_nxt = ST_RESET;
		endcase
	end

	// state moves on a rising test clock edge, or to reset while trst is low
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			st_r <= ST_RESET;
		else if (clk_en && !trst_sync_n)
			st_r <= ST_RESET;
		else if (rise)
			st_r <= st_nxt;
	end

	// tms-high rising edges in a row, read only by the reset check
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			hi_run_r <= 3'h0;
		else if (rise && !tms_v)
			hi_run_r <= 3'h0;
		else if (rise && hi_run_r != 3'(`BST_TMS_RESET_N - 1))
			hi_run_r <= hi_run_r + 3'h1;
	end

	// instruction register
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ir_sh_r <= `BST_IR_CAPTURE;
			ir_r    <= `BST_IR_RESET;
		end
		else if (clk_en && (!trst_sync_n || st_r == ST_RESET))
			ir_r <= `BST_IR_RESET;
		else if (rise)
		begin
			case (st_r)
				ST_CAP_IR: ir_sh_r <= `BST_IR_CAPTURE;
				ST_SH_IR:  ir_sh_r <= {tdi_v, ir_sh_r[`BST_IR_W-1:1]};
				ST_UPD_IR: ir_r    <= ir_sh_r;
				default:   ir_sh_r <= ir_sh_r;
			endcase
		end
	end

	// instruction decode
	always_comb
	begin
		case (ir_r)
			`BST_OP_EXTEST: sel = SEL_BSR;
			`BST_OP_SAMPLE: sel = SEL_BSR;
			`BST_OP_IDCODE: sel = SEL_ID;
			`BST_OP_HIZ:    sel = SEL_BYPASS;
			`BST_OP_BYPASS: sel = SEL_BYPASS;
			default:        sel = SEL_BYPASS;
		endcase
	end

	// data registers in parallel, only the selected one moves
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			byp_r    <= 1'h0;
			bsr_sh_r <= {`BST_BSR_W{1'h0}};
			id_sh_r  <= {`BST_ID_W{1'h0}};
		end
		else if (rise)
		begin
			if (st_r == ST_CAP_DR)
			begin
				case (sel)
					SEL_BSR: bsr_sh_r <= (ir_r == `BST_OP_EXTEST) ? pin_in : core_out;
					SEL_ID:  id_sh_r  <= {ID_VERSION, ID_PART, ID_MAKER, `BST_ID_LSB};
					default: byp_r    <= 1'h0;
				endcase
			end
			else if (st_r == ST_SH_DR)
			begin
				case (sel)
					SEL_BSR: bsr_sh_r <= {tdi_v, bsr_sh_r[`BST_BSR_W-1:1]};
					SEL_ID:  id_sh_r  <= {tdi_v, id_sh_r[`BST_ID_W-1:1]};
					default: byp_r    <= tdi_v;
				endcase
			end
		end
	end

	// parallel output latches of the boundary cells
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			bsr_upd_r <= {`BST_BSR_W{1'h0}};
		else if (rise && st_r == ST_UPD_DR && sel == SEL_BSR)
			bsr_upd_r <= bsr_sh_r;
	end

	always_comb
	begin
		case (sel)
			SEL_BSR: sout = bsr_sh_r[0];
			SEL_ID:  sout = id_sh_r[0];
			default: sout = byp_r;
		endcase
		if (st_r == ST_SH_IR)
			sout = ir_sh_r[0];
	end

	// tdo changes on the falling test clock edge
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tdo    <= 1'h0;
			tdo_oe <= 1'h0;
		end
		else if (fall)
		begin
			tdo    <= sout;
			tdo_oe <= (st_r == ST_SH_DR) || (st_r == ST_SH_IR);
		end
	end

	// test port wins over the fifo; bypass and sample leave pins alone
	assign test_override = (ir_r == `BST_OP_EXTEST) || (ir_r == `BST_OP_HIZ);
	assign outputs_hiz   = (ir_r == `BST_OP_HIZ);
	assign pin_out       = (ir_r == `BST_OP_EXTEST) ? bsr_upd_r : core_out;
	assign tap_in_reset  = (st_r == ST_RESET);

	chk_tms_reset: assert property (@(posedge clock) disable iff (!rstn)
		(rise && tms_v && hi_run_r == 3'(`BST_TMS_RESET_N - 1)) |=> st_r == ST_RESET)
		else $error("five tms highs did not reset tap");
	chk_state_hold: assert property (@(posedge clock) disable iff (!rstn)
		(!rise && trst_sync_n) |=> $stable(st_r))
		else $error("state moved without rising edge");
	chk_exit_upd: assert property (@(posedge clock) disable iff (!rstn)
		(rise && tms_v && trst_sync_n && (st_r == ST_EX1_DR || st_r == ST_EX2_DR)) |=> st_r == ST_UPD_DR)
		else $error("exit with tms high missed update");
	chk_exit_hold: assert property (@(posedge clock) disable iff (!rstn)
		(st_r == ST_EX1_DR || st_r == ST_EX2_DR) |=> $stable(bsr_sh_r) && $stable(id_sh_r) && $stable(byp_r))
		else $error("data register moved in exit");
	chk_pause_hold: assert property (@(posedge clock) disable iff (!rstn)
		(st_r == ST_PAU_DR) |=> $stable(bsr_sh_r) && $stable(id_sh_r) && $stable(byp_r))
		else $error("data register moved in pause");
	chk_ir_update: assert property (@(posedge clock) disable iff (!rstn)
		(st_r != ST_UPD_IR && st_r != ST_RESET && trst_sync_n) |=> $stable(ir_r))
		else $error("instruction changed outside update");
	chk_ir_latch: assert property (@(posedge clock) disable iff (!rstn)
		(rise && trst_sync_n && st_r == ST_UPD_IR) |=> ir_r == $past(ir_sh_r))
		else $error("instruction not latched at update");
	chk_ir_capture: assert property (@(posedge clock) disable iff (!rstn)
		(rise && trst_sync_n && st_r == ST_CAP_IR) |=> ir_sh_r == `BST_IR_CAPTURE)
		else $error("instruction capture pattern missing");
	chk_ir_shift: assert property (@(posedge clock) disable iff (!rstn)
		(rise && trst_sync_n && st_r == ST_SH_IR) |=> ir_sh_r[3] == $past(tdi_v) && {1'h0, ir_sh_r[2:0]} == ($past(ir_sh_r) >> 1))
		else $error("instruction shift not lsb first");
	chk_dr_update: assert property (@(posedge clock) disable iff (!rstn)
		(rise && st_r == ST_UPD_DR && sel == SEL_BSR) |=> bsr_upd_r == $past(bsr_sh_r))
		else $error("boundary latch not updated");
	chk_bypass_zero: assert property (@(posedge clock) disable iff (!rstn)
		(rise && st_r == ST_CAP_DR && sel == SEL_BYPASS) |=> !byp_r)
		else $error("bypass not cleared on capture");
	chk_bypass_shift: assert property (@(posedge clock) disable iff (!rstn)
		(rise && st_r == ST_SH_DR && sel == SEL_BYPASS) |=> byp_r == $past(tdi_v))
		else $error("bypass stage did not take tdi");
	chk_id_capture: assert property (@(posedge clock) disable iff (!rstn)
		(rise && st_r == ST_CAP_DR && sel == SEL_ID) |=> id_sh_r[0] == `BST_ID_LSB)
		else $error("id capture lost its marker bit");
	chk_undecoded: assert property (@(posedge clock) disable iff (!rstn)
		(ir_r > `BST_OP_HIZ) |-> sel == SEL_BYPASS)
		else $error("undecoded code not bypass");
	chk_tdo_fall: assert property (@(posedge clock) disable iff (!rstn)
		!fall |=> $stable(tdo))
		else $error("tdo changed off falling edge");
	chk_bypass_pins: assert property (@(posedge clock) disable iff (!rstn)
		(sel == SEL_BYPASS && !outputs_hiz) |-> pin_out == core_out && !test_override)
		else $error("bypass disturbed device pins");
	chk_pin_extest: assert property (@(posedge clock) disable iff (!rstn)
		(ir_r == `BST_OP_EXTEST) |-> pin_out == bsr_upd_r && test_override)
		else $error("extest did not drive pins");
	chk_en_freeze: assert property (@(posedge clock) disable iff (!rstn)
		!clk_en |=> $stable(st_r) && $stable(ir_r) && $stable(tdo))
		else $error("state moved with clock enable low");
endmodule

// [sim/bst_host.sv]
`timescale 1ns/100ps
module bst_host
(
	// test port pins
	output logic        test_port_clock,
	output logic        tms,
	output logic        tdi,
	output logic        trst_n,
	input  wire logic   tdo,
	// scan results
	output logic [31:0] res,
	output logic        res_v
);
	initial
	begin
		test_port_clock = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		trst_n = 1'h1;
		res = 32'h0;
		res_v = 1'h0;
	end
	// tck stands low between cycles; tdo taken at the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#160 test_port_clock = 1'h1;
		o = tdo;
		#160 test_port_clock = 1'h0;
	endtask
	task automatic walk(input logic [7:0] path, input int n);
		logic o;
		for (int i = 0; i < n; i++)
			step(path[i], 1'h1, o);
	endtask
	task automatic pulse_trst();
		trst_n = 1'h0;
		#400 trst_n = 1'h1;
		#400;
	endtask
	// idle to idle; pz parks in pause after four bits
	task automatic scan(input logic ir, input logic [31:0] din, input int n, input logic pz);
		logic [31:0] q;
		logic        o;
		q = 32'h0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1 || (pz && i == 3), din[i], o);
			q[i] = o;
			if (pz && i == 3)
				walk(8'h08, 5);
		end
		walk(8'h01, 2);
		res = q;
		res_v = 1'h1;
		#40 res_v = 1'h0;
	endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
`include "bst_cfg.svh"
module tb_top;
	localparam logic [31:0] ID_EXP = {4'h5, 16'h1234, 11'h2a5, 1'h1};
	logic        clock;
	logic        rstn;
	logic        tck, tms, tdi, trst_n, tdo, tdo_oe;
	logic [7:0]  pin_in, core_out, pin_out;
	logic        test_override, outputs_hiz, tap_in_reset;
	logic [31:0] res, d;
	logic        res_v;
	logic        clk_en;
	logic        oe_seen = 1'h0;
	logic [3:0]  code;
	logic [31:0] exp_q[$];
	int          num_errors = 0;
	int          compares = 0;
	int          seed = 32'h88a4d899;

	initial clock = 1'h0;
	always #20 clock = ~clock;

	// identity parameters: arbitrary values
	bst_tap #(.ID_VERSION(4'h5), .ID_PART(16'h1234), .ID_MAKER(11'h2a5)) bst_tap_inst (.clock(clock), .rstn(rstn),
		.clk_en(clk_en), .test_port_clock(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
		.pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .test_override(test_override),
		.outputs_hiz(outputs_hiz), .tap_in_reset(tap_in_reset));
	bst_host bst_host_inst (.test_port_clock(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.res(res), .res_v(res_v));

	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic cmp_pins(input logic [10:0] want);
		cmp({20'h0, tdo_oe, tap_in_reset, test_override, outputs_hiz, pin_out}, {21'h0, want});
	endtask
	task automatic scan_exp(input logic ir, input logic [31:0] din, input int n, input logic pz, input logic [31:0] w);
		exp_q.push_back(w);
		bst_host_inst.scan(ir, din, n, pz);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// each scan result against the oldest note
	always @(posedge res_v)
		cmp(res, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);

	// tdo enable must be seen high while a scan shifts
	always @(posedge tck)
		if (tdo_oe)
			oe_seen = 1'h1;

	initial
	begin
		repeat (90000) @(posedge clock);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		rstn = 1'h0;
		clk_en = 1'h1;
		pin_in = 8'h0;
		core_out = 8'h0;
		repeat (10) @(posedge clock);
		#1 rstn = 1'h1;
		bst_host_inst.pulse_trst();
		cmp_pins({3'h4, core_out});
		bst_host_inst.walk(8'h00, 1);
		scan_exp(1'h1, {28'h0, `BST_OP_IDCODE}, 4, 1'h0, 32'h1);
		scan_exp(1'h0, $random(seed), 32, 1'h0, ID_EXP);
		scan_exp(1'h0, $random(seed), 32, 1'h1, ID_EXP);
		cmp({31'h0, oe_seen}, 32'h1);
		$display("test ident done");
		for (int c = 3; c < 16; c++)
		begin
			code = c[3:0];
			d = $random(seed);
			@(posedge clock);
			#1 core_out = d[15:8];
			scan_exp(1'h1, {28'h0, code}, 4, 1'h0, 32'h1);
			scan_exp(1'h0, d, 2, 1'h0, {30'h0, d[0], 1'h0});
			cmp_pins({1'h0, code == `BST_OP_HIZ, code == `BST_OP_HIZ, core_out});
		end
		$display("test bypass codes done");
		d = $random(seed);
		@(posedge clock);
		#1 core_out = d[15:8];
		pin_in = d[23:16];
		scan_exp(1'h1, {28'h0, `BST_OP_SAMPLE}, 4, 1'h0, 32'h1);
		scan_exp(1'h0, {24'h0, d[7:0]}, 8, 1'h0, {24'h0, d[15:8]});
		scan_exp(1'h1, {28'h0, `BST_OP_EXTEST}, 4, 1'h0, 32'h1);
		cmp_pins({3'h2, d[7:0]});
		scan_exp(1'h0, {24'h0, d[31:24]}, 8, 1'h1, {24'h0, d[23:16]});
		cmp_pins({3'h2, d[31:24]});
		$display("test boundary done");
		clk_en = 1'h0;
		bst_host_inst.walk(8'h1f, 5);
		clk_en = 1'h1;
		cmp_pins({3'h2, d[31:24]});
		$display("test clock enable done");
		scan_exp(1'h1, {28'h0, `BST_OP_HIZ}, 4, 1'h0, 32'h1);
		bst_host_inst.walk(8'h79, 7);
		cmp_pins({3'h3, core_out});
		bst_host_inst.walk(8'h01, 1);
		cmp_pins({3'h4, core_out});
		$display("test tms reset done");
		tally_and_finish();
	end
endmodule
